// >>> common/spi_cfg_pkg.sv
// Constants, types and helpers shared by the serial configuration port files.
package spi_cfg_pkg;

  // ----------------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int WORD_W = 16;
  localparam int DATA_W = 8;
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam int RW_BIT = 15;

  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_SETUP_A = 15'h0000;
  localparam logic [ADDR_W-1:0] ADDR_SETUP_B = 15'h0001;
  localparam logic [DATA_W-1:0] SETUP_A_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SETUP_B_RESET = 8'h00;
  localparam int A_SOFT_RST_HI = 7;
  localparam int A_LSB_FIRST_M = 6;
  localparam int A_ASCEND_M = 5;
  localparam int A_ASCEND = 2;
  localparam int A_LSB_FIRST = 1;
  localparam int A_SOFT_RST_LO = 0;
  localparam int B_SINGLE = 7;
  localparam int B_DP_RST = 1;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int BOOT_WAIT_MS = 5;
  localparam int BOOT_WAIT_CYCLES = (BOOT_WAIT_MS * CLK_HZ + 999) / 1000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_HOLD = 4'b1000
  } frame_state_t;

  // Shifts one serial bit into the receive word in the selected order.
  function automatic logic [WORD_W-1:0] shift_in(logic [WORD_W-1:0] sh, logic b, logic lsb);
    if (lsb) begin
      return {b, sh[WORD_W-1:1]};
    end
    return {sh[WORD_W-2:0], b};
  endfunction

  // Picks the received byte out of the receive word.
  function automatic logic [DATA_W-1:0] rx_byte(logic [WORD_W-1:0] sh, logic lsb);
    if (lsb) begin
      return sh[WORD_W-1:DATA_W];
    end
    return sh[DATA_W-1:0];
  endfunction

endpackage

// >>> common/cfg_bus_if.sv
// Internal bus between the serial frame logic and the configuration registers.
`timescale 1ns/1ns
interface cfg_bus_if;
  logic wr_en;
  logic [14:0] waddr;
  logic [14:0] raddr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic clr;
  logic soft_req;
  logic lsb_first;
  logic addr_ascend;
  logic single_instr;
  logic dp_reset;

  modport port (
    output wr_en, waddr, raddr, wdata, clr,
    input rdata, soft_req, lsb_first, addr_ascend, single_instr, dp_reset
  );
  modport regs (
    input wr_en, waddr, raddr, wdata, clr,
    output rdata, soft_req, lsb_first, addr_ascend, single_instr, dp_reset
  );
endinterface

// >>> core/cfg_regs.sv
// The two serial port setup registers and their self-clearing controls.
`timescale 1ns/1ns
module cfg_regs
  import spi_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  cfg_bus_if.regs bus
);

  logic lsb_q, lsb_d;
  logic asc_q, asc_d;
  logic single_q, single_d;
  logic dp_q, dp_d;
  logic soft_q, soft_d;
  logic wr_a, wr_b;

  assign wr_a = bus.wr_en && (bus.waddr == ADDR_SETUP_A);
  assign wr_b = bus.wr_en && (bus.waddr == ADDR_SETUP_B);

  always_comb begin
    lsb_d = lsb_q;
    asc_d = asc_q;
    single_d = single_q;
    soft_d = soft_q;
    dp_d = 1'b0;
    if (bus.clr) begin
      lsb_d = SETUP_A_RESET[A_LSB_FIRST];
      asc_d = SETUP_A_RESET[A_ASCEND];
      single_d = SETUP_B_RESET[B_SINGLE];
      soft_d = 1'b0;
    end
    if (wr_a) begin
      // Either mirror copy may be written; a one in either selects the option.
      lsb_d = bus.wdata[A_LSB_FIRST_M] | bus.wdata[A_LSB_FIRST]; // [R3]
      asc_d = bus.wdata[A_ASCEND_M] | bus.wdata[A_ASCEND]; // [R4]
      // Set wins over a clear in the same cycle.
      if (bus.wdata[A_SOFT_RST_HI] || bus.wdata[A_SOFT_RST_LO]) begin
        soft_d = 1'b1; // [R1]
      end
    end
    if (wr_b) begin
      single_d = bus.wdata[B_SINGLE]; // [R5]
      dp_d = bus.wdata[B_DP_RST]; // [R6]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lsb_q <= 1'b0;
      asc_q <= 1'b0;
      single_q <= 1'b0;
      dp_q <= 1'b0;
      soft_q <= 1'b0;
    end else begin
      lsb_q <= lsb_d;
      asc_q <= asc_d;
      single_q <= single_d;
      dp_q <= dp_d;
      soft_q <= soft_d;
    end
  end

  // Self-clearing bits always read back as zero.
  always_comb begin
    bus.rdata = 8'h00;
    if (bus.raddr == ADDR_SETUP_A) begin
      bus.rdata[A_LSB_FIRST_M] = lsb_q;
      bus.rdata[A_LSB_FIRST] = lsb_q;
      bus.rdata[A_ASCEND_M] = asc_q;
      bus.rdata[A_ASCEND] = asc_q;
    end else if (bus.raddr == ADDR_SETUP_B) begin
      bus.rdata[B_SINGLE] = single_q;
    end
  end

  assign bus.soft_req = soft_q;
  assign bus.lsb_first = lsb_q;
  assign bus.addr_ascend = asc_q;
  assign bus.single_instr = single_q;
  assign bus.dp_reset = dp_q;

  AST_DP_RST_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    wr_b && bus.wdata[B_DP_RST] |=> bus.dp_reset ##1 !bus.dp_reset) // [R6]
    else $error("datapath reset did not pulse for exactly one cycle");
  AST_SOFT_BITS_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    bus.raddr == ADDR_SETUP_A |-> !bus.rdata[A_SOFT_RST_HI] && !bus.rdata[A_SOFT_RST_LO]) // [R1]
    else $error("soft reset bit did not read back as zero");
  AST_MIRROR_READ: assert property (@(posedge clk) disable iff (!rstn)
    bus.raddr == ADDR_SETUP_A |-> bus.rdata[A_LSB_FIRST_M] == bus.rdata[A_LSB_FIRST]) // [R3]
    else $error("bit order mirror copies differ");

endmodule // cfg_regs

// >>> core/spi_config_top.sv
// Serial control port: frame decoding, bit order, streaming and soft resets.
`timescale 1ns/1ns
//
// How it works
// [R1] Writing 1 to bit 7 or bit 0 of setup A resets the port and all registers and self-clears.
// [R2] The host waits 5 ms after a soft reset before writing other registers; boot_busy shows it.
// [R3] Bit 6, mirrored in bit 1, of setup A selects LSB first when 1 and MSB first when 0.
// [R4] Multibyte transfers auto-increment the address whatever the ascension bits hold.
// [R5] Bit 7 of setup B at 1 limits a transaction to one byte; at 0 streaming is allowed.
// [R6] Writing 1 to bit 1 of setup B pulses the datapath reset and the bit self-clears.
// [R7] A soft reset written by the host takes effect once chip select is released.
module spi_config_top
  import spi_cfg_pkg::*;
#(
  parameter int BOOT_CYCLES = BOOT_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Serial pins
  input wire logic serial_clk,
  input wire logic serial_select_n,
  input wire logic serial_din,
  output logic serial_dout,
  output logic serial_dout_oe_n,
  // Controls to the rest of the device
  output logic lsb_first,
  output logic addr_ascend,
  output logic single_instr,
  output logic datapath_reset,
  output logic port_reset,
  output logic boot_busy
);

  localparam int BOOT_W = $clog2(BOOT_CYCLES + 1);

  cfg_bus_if bus ();

  cfg_regs u_regs (
    .clk(clk),
    .rstn(rstn),
    .bus(bus)
  );

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  logic sclk_m_q, sclk_s_q, sclk_p_q;
  logic seln_m_q, seln_s_q, seln_p_q;
  logic din_m_q, din_s_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_p_q <= 1'b0;
      seln_m_q <= 1'b1;
      seln_s_q <= 1'b1;
      seln_p_q <= 1'b1;
      din_m_q <= 1'b0;
      din_s_q <= 1'b0;
    end else begin
      sclk_m_q <= serial_clk;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q;
      seln_m_q <= serial_select_n;
      seln_s_q <= seln_m_q;
      seln_p_q <= seln_s_q;
      din_m_q <= serial_din;
      din_s_q <= din_m_q;
    end
  end

  logic sclk_rise, sclk_fall, selected, sel_end;
  assign sclk_rise = sclk_s_q && !sclk_p_q;
  assign sclk_fall = !sclk_s_q && sclk_p_q;
  assign selected = !seln_s_q;
  assign sel_end = seln_s_q && !seln_p_q;

  // ----------------------------------------------------------------------------
  // Frame logic
  // ----------------------------------------------------------------------------
  frame_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [WORD_W-1:0] sh_q, sh_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] tx_q, tx_d;
  logic rd_q, rd_d;
  logic dout_q, dout_d;
  logic oe_n_q, oe_n_d;
  logic soft_q, soft_d;
  logic wr_en;
  logic [DATA_W-1:0] wdata;
  logic byte_done;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    addr_d = addr_q;
    tx_d = tx_q;
    rd_d = rd_q;
    dout_d = dout_q;
    wr_en = 1'b0;
    wdata = 8'h00;
    byte_done = 1'b0;
    if (sclk_rise) begin
      sh_d = shift_in(sh_q, din_s_q, bus.lsb_first); // [R3]
    end
    case (state_q)
      ST_IDLE: begin
        cnt_d = 4'h0;
        if (selected) begin
          state_d = ST_INSTR;
        end
      end
      ST_INSTR: begin
        if (sclk_rise) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == INSTR_LAST) begin
            rd_d = sh_d[RW_BIT];
            addr_d = sh_d[ADDR_W-1:0];
            state_d = ST_DATA;
            cnt_d = 4'h0;
            tx_d = bus.rdata;
          end
        end
      end
      ST_DATA: begin
        if (sclk_rise) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == DATA_LAST) begin
            byte_done = 1'b1;
            cnt_d = 4'h0;
            wr_en = !rd_q;
            wdata = rx_byte(sh_d, bus.lsb_first); // [R3]
            if (bus.single_instr) begin
              state_d = ST_HOLD; // [R5]
            end else begin
              // Both ascension settings increment, so the bits steer nothing here.
              addr_d = addr_q + 15'h0001; // [R4]
              tx_d = bus.rdata;
            end
          end
        end else if (sclk_fall && rd_q) begin
          dout_d = bus.lsb_first ? tx_q[0] : tx_q[DATA_W-1]; // [R3]
          tx_d = bus.lsb_first ? {1'b0, tx_q[DATA_W-1:1]} : {tx_q[DATA_W-2:0], 1'b0};
        end
      end
      ST_HOLD: begin
        cnt_d = 4'h0;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (!selected || soft_q) begin
      state_d = ST_IDLE;
      cnt_d = 4'h0;
    end
  end

  // Read data is looked up at the address the frame moves to, so the byte is ready
  // before its first falling edge.
  assign bus.raddr = addr_d;
  assign bus.waddr = addr_q;
  assign bus.wr_en = wr_en;
  assign bus.wdata = wdata;

  // The port drives its output only while a read transfers data bytes.
  assign oe_n_d = !((state_d == ST_DATA) && rd_d);
  // The reset waits for chip select to rise so the write that carries it ends cleanly.
  assign soft_d = sel_end && bus.soft_req; // [R7]
  assign bus.clr = soft_q; // [R1]

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 16'h0000;
      addr_q <= 15'h0000;
      tx_q <= 8'h00;
      rd_q <= 1'b0;
      dout_q <= 1'b0;
      oe_n_q <= 1'b1;
      soft_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      tx_q <= tx_d;
      rd_q <= rd_d;
      dout_q <= dout_d;
      oe_n_q <= oe_n_d;
      soft_q <= soft_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Boot wait after a soft reset
  // ----------------------------------------------------------------------------
  // The wait is only reported; writes during it are not blocked, the host must hold off.
  logic [BOOT_W-1:0] boot_q, boot_d;
  logic busy_q, busy_d;

  always_comb begin
    boot_d = boot_q;
    if (soft_q) begin
      boot_d = BOOT_W'(BOOT_CYCLES); // [R2]
    end else if (boot_q != '0) begin
      boot_d = boot_q - BOOT_W'(1);
    end
    busy_d = (boot_d != '0);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot_q <= '0;
      busy_q <= 1'b0;
    end else begin
      boot_q <= boot_d;
      busy_q <= busy_d;
    end
  end

  assign serial_dout = dout_q;
  assign serial_dout_oe_n = oe_n_q;
  assign lsb_first = bus.lsb_first;
  assign addr_ascend = bus.addr_ascend;
  assign single_instr = bus.single_instr;
  assign datapath_reset = bus.dp_reset;
  assign port_reset = soft_q;
  assign boot_busy = busy_q;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  AST_RESET_AFTER_SELECT: assert property (@(posedge clk) disable iff (!rstn)
    port_reset |-> !selected && $past(bus.soft_req)) // [R7]
    else $error("soft reset fired while chip select was active");
  AST_RESET_CLEARS: assert property (@(posedge clk) disable iff (!rstn)
    port_reset |=> !lsb_first && !single_instr && !addr_ascend && state_q == ST_IDLE) // [R1]
    else $error("soft reset left registers or frame state set");
  AST_LSB_LAST_BIT: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && lsb_first |-> wdata[DATA_W-1] == din_s_q) // [R3]
    else $error("LSB first byte assembled in wrong order");
  AST_MSB_LAST_BIT: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && !lsb_first |-> wdata[0] == din_s_q) // [R3]
    else $error("MSB first byte assembled in wrong order");
  AST_ADDR_INC: assert property (@(posedge clk) disable iff (!rstn)
    byte_done && !single_instr && selected && !soft_q |=> addr_q == $past(addr_q) + 15'h0001) // [R4]
    else $error("address did not increment after a streamed byte");
  AST_SINGLE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    byte_done && single_instr && selected |=> state_q == ST_HOLD && !wr_en) // [R5]
    else $error("single instruction mode kept transferring");
  AST_BOOT_BUSY: assert property (@(posedge clk) disable iff (!rstn)
    port_reset |=> boot_busy [*8]) // [R2]
    else $error("boot wait not reported after soft reset");

  COV_SOFT_RESET: cover property (@(posedge clk) disable iff (!rstn) port_reset);
  COV_STREAM_READ: cover property (@(posedge clk) disable iff (!rstn)
    byte_done && rd_q && !single_instr ##[1:400] byte_done && rd_q);
  COV_SINGLE_HOLD: cover property (@(posedge clk) disable iff (!rstn) state_q == ST_HOLD);
  COV_DP_RESET: cover property (@(posedge clk) disable iff (!rstn) datapath_reset);

endmodule // spi_config_top

// >>> verification/serial_host.sv
// Serial bus host model that sends frames to the configuration port.
`timescale 1ns/1ns
module serial_host (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic serial_clk,
  output logic serial_select_n,
  output logic serial_din,
  input wire logic serial_dout,
  input wire logic serial_dout_oe_n,
  // Device status
  input wire logic boot_busy,
  // Received bytes
  output logic rx_stb,
  output logic [8:0] rx_word
);
  logic lsb = 1'b0;
  logic [7:0] wr_q[$];

  initial begin
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    serial_din = 1'b0;
    rx_stb = 1'b0;
    rx_word = 9'h000;
  end

  // Six clk cycles a phase keeps clear of the three that the synchronisers need.
  task automatic one_bit(input logic b, output logic o, output logic oe_n);
    serial_din = b;
    repeat (6) @(negedge clk);
    o = serial_dout;
    oe_n = serial_dout_oe_n;
    serial_clk = 1'b1;
    repeat (6) @(negedge clk);
    serial_clk = 1'b0;
  endtask

  task automatic frame(input logic rd, input logic [14:0] addr, input int n);
    logic [15:0] w;
    logic [7:0] d;
    logic o;
    logic oe_n;
    logic bad;
    int j;
    w = {rd, addr};
    @(negedge clk);
    serial_select_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 16; i++) begin
      one_bit(lsb ? w[i] : w[15-i], o, oe_n);
    end
    for (int k = 0; k < n; k++) begin
      d = rd ? 8'h00 : wr_q.pop_front();
      bad = 1'b0;
      for (int i = 0; i < 8; i++) begin
        j = lsb ? i : 7 - i;
        one_bit(d[j], o, oe_n);
        if (rd) begin
          d[j] = o;
        end
        bad = bad | oe_n;
      end
      if (rd) begin
        rx_word = {bad, d};
        rx_stb = 1'b1;
        @(negedge clk);
        rx_stb = 1'b0;
      end
    end
    repeat (6) @(negedge clk);
    serial_select_n = 1'b1;
    // A released data line must not keep looking valid.
    serial_din = ~serial_din;
    repeat (8) @(negedge clk);
  endtask

  task automatic wait_boot();
    repeat (2) @(negedge clk);
    while (boot_busy !== 1'b0) begin
      @(negedge clk);
    end
  endtask
endmodule // serial_host

// >>> verification/test_spi_config_registers.sv
// Self-checking testbench for the serial configuration registers.
`timescale 1ns/1ns
module test_spi_config_registers;
  import spi_cfg_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic serial_clk, serial_select_n, serial_din, serial_dout, serial_dout_oe_n;
  logic lsb_first, addr_ascend, single_instr, datapath_reset, port_reset, boot_busy;
  logic rx_stb;
  logic [8:0] rx_word;
  logic [9:0] exp_q[$];
  logic [9:0] e;
  logic [7:0] sr[2] = '{8'h80, 8'h01};
  int fail_count = 0;
  int total_checks = 0;
  int dp_pulses = 0;
  int port_pulses = 0;
  int p0;
  logic [14:0] a;
  logic [7:0] d;

  always #25 clk = ~clk;

  spi_config_top #(.BOOT_CYCLES(20)) dut_u (.clk(clk), .rstn(rstn), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .serial_din(serial_din), .serial_dout(serial_dout),
    .serial_dout_oe_n(serial_dout_oe_n), .lsb_first(lsb_first), .addr_ascend(addr_ascend),
    .single_instr(single_instr), .datapath_reset(datapath_reset), .port_reset(port_reset),
    .boot_busy(boot_busy));

  serial_host host_u (.clk(clk), .serial_clk(serial_clk), .serial_select_n(serial_select_n),
    .serial_din(serial_din), .serial_dout(serial_dout), .serial_dout_oe_n(serial_dout_oe_n),
    .boot_busy(boot_busy), .rx_stb(rx_stb), .rx_word(rx_word));

  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [14:0] addr, input logic [7:0] b);
    host_u.wr_q.push_back(b);
    host_u.frame(1'b0, addr, 1);
  endtask

  task automatic rd(input logic [14:0] addr, input logic [7:0] b);
    exp_q.push_back({2'b10, b});
    host_u.frame(1'b1, addr, 1);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (rx_stb === 1'b1) begin
      e = exp_q.pop_front();
      if (e[9]) begin
        chk("read byte", e[8:0], rx_word);
      end else begin
        chk("read drive off", {8'h00, e[8]}, {8'h00, rx_word[8]});
      end
    end
  end

  // Registered pulses are looked at mid-cycle, where they have settled.
  always @(negedge clk) begin
    if (datapath_reset === 1'b1) begin
      dp_pulses++;
    end
    if (port_reset === 1'b1) begin
      port_pulses++;
      chk("select at soft reset", 9'h001, {8'h00, serial_select_n});
    end
  end

  initial begin
    #(60000 * 50);
    fail_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    end_sim();
  end

  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial begin
    void'($urandom(15));
    repeat (3) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    repeat (4) @(negedge clk);
    rd(ADDR_SETUP_A, SETUP_A_RESET);
    rd(ADDR_SETUP_B, SETUP_B_RESET);
    chk("controls", 9'h000, {5'h00, lsb_first, addr_ascend, single_instr, boot_busy});
    $display("test reset_values done");
    wr(ADDR_SETUP_B, 8'h02);
    rd(ADDR_SETUP_B, 8'h00);
    chk("datapath pulses", 9'd1, 9'(dp_pulses));
    $display("test datapath_reset done");
    for (int i = 0; i < 4; i++) begin
      a = 15'($urandom_range(32767, 2));
      d = 8'($urandom);
      wr(a, d);
      rd(a, 8'h00);
    end
    wr(ADDR_SETUP_B, 8'h7D);
    rd(ADDR_SETUP_B, 8'h00);
    chk("datapath pulses", 9'd1, 9'(dp_pulses));
    $display("test unmapped_reserved done");
    host_u.wr_q.push_back(8'h24);
    host_u.wr_q.push_back(8'h80);
    host_u.frame(1'b0, ADDR_SETUP_A, 2);
    chk("ascend single", 9'h003, {7'h00, addr_ascend, single_instr});
    rd(ADDR_SETUP_B, 8'h80);
    exp_q.push_back({2'b10, 8'h24});
    exp_q.push_back({2'b01, 8'h00});
    host_u.frame(1'b1, ADDR_SETUP_A, 2);
    host_u.wr_q.push_back(8'h00);
    host_u.wr_q.push_back(8'h00);
    host_u.frame(1'b0, ADDR_SETUP_A, 2);
    rd(ADDR_SETUP_B, 8'h80);
    wr(ADDR_SETUP_B, 8'h00);
    wr(ADDR_SETUP_A, 8'h04);
    exp_q.push_back({2'b10, 8'h24});
    exp_q.push_back({2'b10, 8'h00});
    host_u.frame(1'b1, ADDR_SETUP_A, 2);
    $display("test streaming done");
    wr(ADDR_SETUP_A, 8'h02);
    host_u.lsb = 1'b1;
    rd(ADDR_SETUP_A, 8'h42);
    wr(ADDR_SETUP_B, 8'h80);
    chk("bit order", 9'h003, {7'h00, lsb_first, single_instr});
    rd(ADDR_SETUP_B, 8'h80);
    wr(ADDR_SETUP_B, 8'h00);
    wr(ADDR_SETUP_A, 8'h00);
    host_u.lsb = 1'b0;
    rd(ADDR_SETUP_A, 8'h00);
    chk("bit order", 9'h000, {8'h00, lsb_first});
    $display("test bit_order done");
    foreach (sr[i]) begin
      wr(ADDR_SETUP_B, 8'h80);
      wr(ADDR_SETUP_A, 8'h60);
      chk("mirror set", 9'h007, {6'h00, lsb_first, addr_ascend, single_instr});
      p0 = port_pulses;
      // The mirror bit has switched the port to LSB first, so the host follows.
      host_u.lsb = 1'b1;
      wr(ADDR_SETUP_A, sr[i]);
      host_u.lsb = 1'b0;
      chk("port pulses", 9'(p0 + 1), 9'(port_pulses));
      chk("after soft reset", 9'h001, {5'h00, lsb_first, addr_ascend, single_instr, boot_busy});
      host_u.wait_boot();
      rd(ADDR_SETUP_A, 8'h00);
      rd(ADDR_SETUP_B, 8'h00);
    end
    $display("test soft_reset done");
    end_sim();
  end
endmodule // test_spi_config_registers
